// [src/cov_top.sv]
// compare output units and interrupt vector logic of a 16-bit timer
// Overview of operation
// - each channel has eight-mode output unit
// - hiz function plus high pin floats outputs
// - non-zero modes change output on clock edge
// - mode 0 output follows software bit immediately
// - mode 1 sets, mode 5 clears on equal
// - mode 4 toggles on each channel equal
// - modes 2/6 toggle, then clear/set on period
// - modes 3/7 set/clear, then opposite on period
// - up mode: actions at compare and period
// - up/down: equality in either direction acts
// - channel 0 events coincide, no special case
// - dedicated channel 0 irq plus shared irq
// - capture or compare sets flag, software too
// - irq needs channel and global enable
// - channel 0 flag cleared on service
// - vector shows highest enabled pending source
// - codes 0, 2*n, 14 for overflow
// - vector access clears reported flag
// - three or seven channels
// - equal event when count reaches latch
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module cov_top
#(
  parameter int NCH = 7 // channel count, 3 or 7
)
(
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [15:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [15:0] RDATA_O,
  input wire logic TICK_I,
  input wire logic [15:0] COUNT_I,
  input wire logic OVERFLOW_I,
  input wire logic [NCH-1:0] CAPTURE_I,
  input wire logic IRQ0_ACK_I,
  input wire logic HIZ_PIN_I,
  output logic [NCH-1:0] OUT_O,
  output logic [NCH-1:0] OUT_OE_N_O,
  output logic IRQ0_O,
  output logic IRQ_SHARED_O
);
  localparam int VW = 4; // vector code width

  // TICK_I marks one timer clock edge; COUNT_I is the count it reaches
  // the counter sits outside, so up, continuous and up/down sequences
  // all arrive here as plain series of counts
  // CAPTURE_I, OVERFLOW_I and IRQ0_ACK_I are one-cycle pulses, same clock
  // HIZ_PIN_I comes from a pin and passes two flops before use

  // register map, byte offsets held in the package
  //   global word: irq enable, float select, clear pulse,
  //     overflow enable, overflow flag
  //   vector word: read or write clears the reported source
  //   latch words: one compare value per channel, one word apart
  //   control words: mode, out bit, irq enable, flag
  //   unmapped words read zero and ignore writes

  // register port request
  cov_pkg::cov_req_t req; // bundled register request

  // channel state
  cov_pkg::cov_chctl_t ctl_r [NCH]; // channel control words
  logic [15:0] latch_r [NCH]; // channel_compare_latch words
  logic [NCH-1:0] flag_r; // channel_flag bits
  logic [NCH-1:0] flag_nxt; // next flag bits

  // global state, clear pulse and read data
  logic ovf_r; // overflow_flag
  logic ovf_nxt; // next overflow flag
  logic gie_r; // global_irq_enable
  logic hiz_sel_r; // output_hiz_pin function selected
  logic ovf_ie_r; // overflow interrupt enable
  logic clear_p; // one-cycle timer clear
  logic [15:0] rdata_r; // read data register

  // pin synchroniser
  logic hiz_s1_r; // pin synchroniser, first stage
  logic hiz_s2_r; // pin synchroniser, second stage

  // events, raw outputs and decode
  logic [NCH-1:0] chan_eq; // channel_equal_event per channel
  logic period_eq; // period_equal_event
  logic [NCH-1:0] out_w; // raw output unit levels
  logic [VW-1:0] vec_code; // current vector code
  logic vec_access; // any access of the vector word
  logic [NCH-1:0] ctl_hit; // channel control word addressed
  logic [NCH-1:0] latch_hit; // compare latch word addressed

  // address of a per-channel word; channel n sits n steps above base
  function automatic logic [7:0] ch_addr(input logic [7:0] base,
                                         input int n);
    ch_addr = base + 8'(n) * cov_pkg::OFS_STEP;
  endfunction

  // prioritised code of enabled pending sources, channel 0 excluded
  function automatic logic [VW-1:0] prio_code(input logic [NCH-1:0] f,
                                             input logic [NCH-1:0] ie,
                                             input logic of,
                                             input logic oie);
    logic [VW-1:0] c;
    c = cov_pkg::VEC_NONE;
    if (of && oie)
      c = cov_pkg::VEC_OVF; // overflow lowest
    // walk down from the top channel, so the lowest pending one
    // writes the code last; channel 0 has its own request
    for (int n = NCH - 1; n >= 1; n--)
      if (f[n] && ie[n])
        c = VW'(2 * n); // lower channel wins
    prio_code = c;
  endfunction

  // bundle the port signals into one request word
  assign req.wr = WR_I;
  assign req.rd = RD_I;
  assign req.addr = ADDR_I;
  assign req.wdata = WDATA_I;

  // address decode of per-channel words
  // one compare per channel and word kind
  always_comb
  begin
    for (int n = 0; n < NCH; n++)
    begin
      ctl_hit[n] = (req.addr == ch_addr(cov_pkg::OFS_CTL0, n));
      latch_hit[n] = (req.addr == ch_addr(cov_pkg::OFS_LATCH0, n));
    end
  end

  // vector access and timer clear strobes
  assign vec_access = (req.wr || req.rd)
                      && (req.addr == cov_pkg::OFS_VECTOR);
  assign clear_p = req.wr && (req.addr == cov_pkg::OFS_GLOBAL)
                   && req.wdata[cov_pkg::GC_CLEAR];

  // output_hiz_pin synchroniser
  // only the second stage feeds logic; the first may be metastable
  // pin idles low, so the reset level matches it
  always_ff @(posedge CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      hiz_s1_r <= 1'b0;
      hiz_s2_r <= 1'b0;
    end
    else
    begin
      hiz_s1_r <= HIZ_PIN_I;
      hiz_s2_r <= hiz_s1_r;
    end
  end

  // global control register
  // the clear bit is a pulse decoded from the write, never stored
  always_ff @(posedge CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      gie_r <= 1'b0;
      hiz_sel_r <= 1'b0;
      ovf_ie_r <= 1'b0;
    end
    else if (req.wr && req.addr == cov_pkg::OFS_GLOBAL)
    begin
      gie_r <= req.wdata[cov_pkg::GC_GIE];
      hiz_sel_r <= req.wdata[cov_pkg::GC_HIZ_SEL];
      ovf_ie_r <= req.wdata[cov_pkg::GC_OVF_IE];
    end
  end

  // channel control and compare latch registers
  // a mode store lands whole, so no half-written mode reaches a unit
  always_ff @(posedge CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      for (int n = 0; n < NCH; n++)
      begin
        ctl_r[n] <= '{cov_pkg::cov_mode_t'(cov_pkg::MODE_RST), 1'b0, 1'b0};
        latch_r[n] <= cov_pkg::LATCH_RST;
      end
    end
    else if (req.wr)
    begin
      for (int n = 0; n < NCH; n++)
      begin
        if (ctl_hit[n])
        begin
          ctl_r[n].mode <= cov_pkg::cov_mode_t'(
            req.wdata[cov_pkg::CC_MODE_LSB +: 3]);
          ctl_r[n].out_val <= req.wdata[cov_pkg::CC_OUT];
          ctl_r[n].irq_en <= req.wdata[cov_pkg::CC_IE];
        end
        if (latch_hit[n])
          latch_r[n] <= req.wdata;
      end
    end
  end

  // equal events: count reaches the latch on a timer tick; the counter
  // supplies up and up/down sequences, so equality in either direction
  // and the period value both act here
  always_comb
  begin
    for (int n = 0; n < NCH; n++)
      chan_eq[n] = TICK_I && (COUNT_I == latch_r[n]);
  end
  // a tick with no match leaves every unit alone
  // the period event is channel 0's own equal event
  assign period_eq = chan_eq[0]; // same as channel 0 event

  // channel flag next values: clears first, sets win
  // later lines override earlier ones, so a set in the same cycle
  // as any clear keeps the flag
  always_comb
  begin
    flag_nxt = flag_r;
    for (int n = 0; n < NCH; n++)
    begin
      if (req.wr && ctl_hit[n])
        flag_nxt[n] = req.wdata[cov_pkg::CC_FLAG]; // software
      if (vec_access && n != 0 && vec_code == VW'(2 * n))
        flag_nxt[n] = 1'b0; // reported flag cleared
      if (n == 0 && IRQ0_ACK_I)
        flag_nxt[n] = 1'b0; // serviced
      if (clear_p)
        flag_nxt[n] = 1'b0;
      if (chan_eq[n] || CAPTURE_I[n])
        flag_nxt[n] = 1'b1; // compare or capture
    end
  end

  // channel flag register
  // one flop per channel, reset to no request pending
  always_ff @(posedge CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
      flag_r <= '0;
    else
      flag_r <= flag_nxt;
  end

  // overflow flag next value
  // same order as the channel flags: software, clears, then set
  always_comb
  begin
    ovf_nxt = ovf_r;
    if (req.wr && req.addr == cov_pkg::OFS_GLOBAL)
      ovf_nxt = req.wdata[cov_pkg::GC_OVF_FLAG]; // software
    if (vec_access && vec_code == cov_pkg::VEC_OVF)
      ovf_nxt = 1'b0;
    if (clear_p)
      ovf_nxt = 1'b0;
    if (OVERFLOW_I)
      ovf_nxt = 1'b1; // set wins
  end

  // overflow flag register
  // set by the counter, cleared by software or a vector access
  always_ff @(posedge CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
      ovf_r <= 1'b0;
    else
      ovf_r <= ovf_nxt;
  end

  // vector code from enabled pending flags
  // disabled sources are masked before the priority walk
  always_comb
  begin
    logic [NCH-1:0] ie;
    ie = '0;
    for (int n = 0; n < NCH; n++)
      ie[n] = ctl_r[n].irq_en;
    vec_code = prio_code(flag_r, ie, ovf_r, ovf_ie_r);
  end

  // interrupt requests
  // channel 0 has its own request and never enters the vector
  // shared request drops when its last enabled source is cleared
  assign IRQ0_O = flag_r[0] && ctl_r[0].irq_en && gie_r;
  assign IRQ_SHARED_O = (vec_code != cov_pkg::VEC_NONE)
                        && gie_r;

  // read data, one cycle after the strobe
  // a vector read takes the code before the same edge clears the flag
  always_ff @(posedge CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
      rdata_r <= '0;
    else if (req.rd)
    begin
      rdata_r <= '0; // unmapped reads zero
      // global word: clear bit always reads zero
      if (req.addr == cov_pkg::OFS_GLOBAL)
      begin
        rdata_r[cov_pkg::GC_GIE] <= gie_r;
        rdata_r[cov_pkg::GC_HIZ_SEL] <= hiz_sel_r;
        rdata_r[cov_pkg::GC_OVF_IE] <= ovf_ie_r;
        rdata_r[cov_pkg::GC_OVF_FLAG] <= ovf_r;
      end
      // vector word: code only, upper bits zero
      if (req.addr == cov_pkg::OFS_VECTOR)
        rdata_r <= 16'(vec_code);
      for (int n = 0; n < NCH; n++)
      begin
        if (ctl_hit[n])
        begin
          rdata_r[cov_pkg::CC_MODE_LSB +: 3] <= ctl_r[n].mode;
          rdata_r[cov_pkg::CC_OUT] <= ctl_r[n].out_val;
          rdata_r[cov_pkg::CC_IE] <= ctl_r[n].irq_en;
          rdata_r[cov_pkg::CC_FLAG] <= flag_r[n];
        end
        if (latch_hit[n])
          rdata_r <= latch_r[n];
      end
    end
  end
  assign RDATA_O = rdata_r;

  // one output unit per channel
  // all units share the period event and the timer clear
  for (genvar g = 0; g < NCH; g++)
  begin : g_unit
    cov_out_unit u_out
    (
      .clk_i(CLK_I),
      .rst_i(RESET_I),
      .ctl_i(ctl_r[g]),
      .chan_eq_i(chan_eq[g]),
      .per_eq_i(period_eq),
      .clear_i(clear_p),
      .out_o(out_w[g])
    );
  end

  // high impedance when the pin function is selected and pin high
  // active-low enable: high floats every output together
  // the pin acts two edges late through its synchroniser
  assign OUT_O = out_w;
  assign OUT_OE_N_O = {NCH{hiz_sel_r && hiz_s2_r}};
endmodule

// [src/cov_pkg.sv]
// package: register map, field positions and types of the compare output block
package cov_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_GLOBAL = 8'h00; // global control
  localparam logic [7:0] OFS_VECTOR = 8'h08; // irq_vector_register
  localparam logic [7:0] OFS_LATCH0 = 8'h10; // channel_compare_latch 0
  localparam logic [7:0] OFS_CTL0 = 8'h40; // channel_control 0
  localparam logic [7:0] OFS_STEP = 8'h04; // spacing of per-channel words
  // global control fields
  localparam int GC_GIE = 0; // global_irq_enable
  localparam int GC_HIZ_SEL = 1; // output_hiz_pin function selected
  localparam int GC_CLEAR = 2; // timer clear, write-one pulse
  localparam int GC_OVF_IE = 3; // overflow interrupt enable
  localparam int GC_OVF_FLAG = 4; // overflow_flag
  // channel control fields
  localparam int CC_MODE_LSB = 0; // output_mode_field, 3 bits
  localparam int CC_OUT = 3; // channel_output_value
  localparam int CC_IE = 4; // channel_irq_enable
  localparam int CC_FLAG = 5; // channel_flag
  // reset values
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic [15:0] LATCH_RST = 16'h0000;
  // vector codes
  localparam logic [3:0] VEC_NONE = 4'h0;
  localparam logic [3:0] VEC_OVF = 4'hE;
  // output modes
  typedef enum logic [2:0] {
    M_OUTPUT, M_SET, M_TOG_RST, M_SET_RST,
    M_TOGGLE, M_RESET, M_TOG_SET, M_RST_SET
  } cov_mode_t;
  // per-channel control carried to the output unit
  typedef struct packed {
    cov_mode_t mode;
    logic out_val;
    logic irq_en;
  } cov_chctl_t;
  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } cov_req_t;
endpackage

// [src/cov_out_unit.sv]
// one channel output unit: eight waveform modes
`timescale 1ns/1ps
module cov_out_unit
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire cov_pkg::cov_chctl_t ctl_i,
  input wire logic chan_eq_i,
  input wire logic per_eq_i,
  input wire logic clear_i,
  output logic out_o
);
  logic out_r; // clocked output level
  logic out_nxt; // next clocked level

  // mode actions on the channel and period events
  always_comb
  begin
    out_nxt = out_r;
    unique case (ctl_i.mode)
      cov_pkg::M_OUTPUT: out_nxt = ctl_i.out_val; // track software bit
      cov_pkg::M_SET: if (chan_eq_i) out_nxt = 1'b1;
      cov_pkg::M_RESET: if (chan_eq_i) out_nxt = 1'b0;
      cov_pkg::M_TOGGLE: if (chan_eq_i) out_nxt = ~out_r;
      cov_pkg::M_TOG_RST:
      begin
        if (chan_eq_i) out_nxt = ~out_r;
        if (per_eq_i) out_nxt = 1'b0;
      end
      cov_pkg::M_TOG_SET:
      begin
        if (chan_eq_i) out_nxt = ~out_r;
        if (per_eq_i) out_nxt = 1'b1;
      end
      cov_pkg::M_SET_RST:
      begin
        if (chan_eq_i) out_nxt = 1'b1;
        if (per_eq_i) out_nxt = 1'b0;
      end
      cov_pkg::M_RST_SET:
      begin
        if (chan_eq_i) out_nxt = 1'b0;
        if (per_eq_i) out_nxt = 1'b1;
      end
    endcase
  end

  // level changes only on the clock edge
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      out_r <= 1'b0;
    else if (clear_i)
      out_r <= 1'b0;
    else
      out_r <= out_nxt;
  end

  // mode 0 passes the software bit at once
  assign out_o = (ctl_i.mode == cov_pkg::M_OUTPUT) ? ctl_i.out_val
                                                   : out_r;
endmodule

// [test/cov_top_properties.sv]
// checker: port-level properties of the compare output block
`timescale 1ns/1ps
module cov_top_properties
#(
  parameter int NCH = 7 // channel count
)
(
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [15:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [15:0] RDATA_O,
  input wire logic TICK_I,
  input wire logic OVERFLOW_I,
  input wire logic [NCH-1:0] CAPTURE_I,
  input wire logic IRQ0_ACK_I,
  input wire logic HIZ_PIN_I,
  input wire logic [NCH-1:0] OUT_O,
  input wire logic [NCH-1:0] OUT_OE_N_O,
  input wire logic IRQ0_O,
  input wire logic IRQ_SHARED_O
);
  logic quiet; // no flag-setting event this cycle
  logic vec_rd; // read of the vector register
  logic irq0_src; // anything able to raise flag 0
  logic shr_src; // anything able to raise a shared source
  logic sel_q; // float function selected, mirrored from writes
  // mirror of the float select bit, same edge as the register
  always_ff @(posedge CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
      sel_q <= 1'b0;
    else if (WR_I && ADDR_I == cov_pkg::OFS_GLOBAL)
      sel_q <= WDATA_I[cov_pkg::GC_HIZ_SEL];
  end
  assign quiet = !TICK_I && !OVERFLOW_I && !(|CAPTURE_I);
  assign vec_rd = RD_I && ADDR_I == cov_pkg::OFS_VECTOR;
  assign irq0_src = WR_I || TICK_I || CAPTURE_I[0];
  assign shr_src = WR_I || !quiet;
  // one clock domain, one reset
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RESET_I);
  out_hold_a: assert property (
    (!TICK_I && !WR_I) |=> $stable(OUT_O)) else $error("output moved idle");
  hiz_off_a: assert property (
    !HIZ_PIN_I [*3] |-> OUT_OE_N_O == '0) else $error("float with pin low");
  oe_all_a: assert property (
    OUT_OE_N_O == '0 || OUT_OE_N_O == '1) else $error("partial float");
  hiz_on_a: assert property (
    HIZ_PIN_I [*2] ##1 (HIZ_PIN_I && sel_q) |-> OUT_OE_N_O == '1)
    else $error("no float with pin high");
  vec_code_a: assert property (
    vec_rd |=> !RDATA_O[0] && RDATA_O <= 16'h000E) else $error("bad code");
  vec_pend_a: assert property (
    vec_rd && IRQ_SHARED_O |=> RDATA_O != 16'h0000) else $error("code zero");
  irq0_cause_a: assert property (
    $rose(IRQ0_O) |-> $past(irq0_src)) else $error("irq0 without cause");
  ack_clr_a: assert property (
    IRQ0_ACK_I && quiet && !WR_I |=> !IRQ0_O) else $error("ack kept irq0");
  clr_all_a: assert property (
    WR_I && ADDR_I == cov_pkg::OFS_GLOBAL && WDATA_I[cov_pkg::GC_CLEAR]
    && quiet |=> !IRQ0_O && !IRQ_SHARED_O) else $error("clear kept irq");
  shr_cause_a: assert property (
    $rose(IRQ_SHARED_O) |-> $past(shr_src)) else $error("shared no cause");
endmodule
bind cov_top cov_top_properties #(.NCH(NCH)) u_props (.CLK_I(CLK_I),
  .RESET_I(RESET_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
  .RD_I(RD_I), .RDATA_O(RDATA_O), .TICK_I(TICK_I), .OVERFLOW_I(OVERFLOW_I),
  .CAPTURE_I(CAPTURE_I), .IRQ0_ACK_I(IRQ0_ACK_I), .HIZ_PIN_I(HIZ_PIN_I),
  .OUT_O(OUT_O), .OUT_OE_N_O(OUT_OE_N_O), .IRQ0_O(IRQ0_O),
  .IRQ_SHARED_O(IRQ_SHARED_O));

// [test/tb_top.sv]
// testbench: register-driven tests of the compare output block
`timescale 1ns/1ps
module tb_top;
  logic CLK_I, RESET_I, WR_I, RD_I, TICK_I, OVERFLOW_I, IRQ0_ACK_I, HIZ_PIN_I;
  logic [7:0] ADDR_I; // register address
  logic [15:0] WDATA_I, COUNT_I, RDATA_O; // bus data and count
  logic [6:0] CAPTURE_I, OUT_O, OUT_OE_N_O; // per-channel lines
  logic IRQ0_O, IRQ_SHARED_O; // requests
  int n_fail, checks_done; // verdict counters
  int cs [3] = '{5, 9, 5}; // channel, period, channel again
  logic v; // expected channel 1 level
  cov_top dut (.CLK_I(CLK_I), .RESET_I(RESET_I), .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
    .TICK_I(TICK_I), .COUNT_I(COUNT_I), .OVERFLOW_I(OVERFLOW_I),
    .CAPTURE_I(CAPTURE_I), .IRQ0_ACK_I(IRQ0_ACK_I), .HIZ_PIN_I(HIZ_PIN_I),
    .OUT_O(OUT_O), .OUT_OE_N_O(OUT_OE_N_O), .IRQ0_O(IRQ0_O),
    .IRQ_SHARED_O(IRQ_SHARED_O));
  // 200 MHz clock
  initial
  begin
    CLK_I = 1'h0;
    forever #2.5 CLK_I = ~CLK_I;
  end
  // word and bit comparisons
  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: word %h not %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: bit %b not %b", $time, got, exp);
    end
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge CLK_I);
    ADDR_I <= a;
    WDATA_I <= d;
    WR_I <= 1'h1;
    @(posedge CLK_I);
    WR_I <= 1'h0;
    #1;
  endtask
  // one-cycle read strobe, data checked in the next cycle
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge CLK_I);
    ADDR_I <= a;
    RD_I <= 1'h1;
    @(posedge CLK_I);
    RD_I <= 1'h0;
    #1;
    cmp_word(RDATA_O, exp);
  endtask
  // one timer tick reaching count c
  task automatic tick(input logic [15:0] c);
    @(posedge CLK_I);
    TICK_I <= 1'h1;
    COUNT_I <= c;
    @(posedge CLK_I);
    TICK_I <= 1'h0;
    #1;
  endtask
  // expected level after a channel (pe=0) or period (pe=1) event
  function automatic logic nxt(input int m, input logic v, input logic pe);
    if (pe)
      return (m == 2 || m == 3) ? 1'h0 : (m >= 6) ? 1'h1 : v;
    return (m == 1 || m == 3) ? 1'h1 : (m == 5 || m == 7) ? 1'h0 :
      (m == 0) ? v : !v;
  endfunction
  // counts, verdict, stop
  task automatic end_of_test();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // watchdog: tests need well under 1000 cycles
  initial
  begin
    repeat (4000) @(posedge CLK_I);
    n_fail++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    end_of_test();
  end
  // main sequence
  initial
  begin
    {WR_I, RD_I, TICK_I, OVERFLOW_I, IRQ0_ACK_I, HIZ_PIN_I} = 6'h00;
    {ADDR_I, WDATA_I, COUNT_I, CAPTURE_I} = '0;
    {n_fail, checks_done} = '0;
    RESET_I = 1'h1;
    repeat (6) @(posedge CLK_I);
    RESET_I <= 1'h0;
    rd(8'h00, 16'h0000);
    rd(8'h08, 16'h0000);
    rd(8'hFC, 16'h0000); // unmapped
    cmp_word({9'h000, OUT_O}, 16'h0000);
    $display("test reset done");
    wr(8'h10, 16'h0009); // period latch
    wr(8'h14, 16'h0005); // channel 1 latch
    for (int m = 1; m < 8; m++)
      for (int p = 0; p < 2; p++)
      begin
        wr(8'h44, {12'h000, p[0], 3'h0}); // mode 0 preset
        cmp_bit(OUT_O[1], p[0]);
        wr(8'h44, {13'h0000, m[2:0]});
        tick(16'h0006);
        cmp_bit(OUT_O[1], p[0]);
        v = p[0];
        foreach (cs[i])
        begin
          tick(cs[i][15:0]);
          v = nxt(m, v, cs[i] == 9);
          cmp_bit(OUT_O[1], v);
        end
      end
    wr(8'h40, 16'h0004); // channel 0 toggle mode
    tick(16'h0009);
    cmp_bit(OUT_O[0], 1'h1);
    tick(16'h0009);
    cmp_bit(OUT_O[0], 1'h0);
    wr(8'h44, 16'h0000);
    $display("test modes done");
    wr(8'h00, 16'h0004); // timer clear
    for (int n = 0; n < 7; n++)
      wr(8'h40 + 8'(4 * n), 16'h0010);
    wr(8'h00, 16'h0009); // global and overflow enable
    @(posedge CLK_I);
    CAPTURE_I <= 7'h7F;
    OVERFLOW_I <= 1'h1;
    @(posedge CLK_I);
    CAPTURE_I <= 7'h00;
    OVERFLOW_I <= 1'h0;
    #1;
    cmp_bit(IRQ0_O, 1'h1);
    cmp_bit(IRQ_SHARED_O, 1'h1);
    for (int n = 1; n < 8; n++)
    begin
      rd(8'h08, 16'(2 * n));
      cmp_bit(IRQ_SHARED_O, n < 7);
    end
    rd(8'h08, 16'h0000);
    wr(8'h48, 16'h0020); // flag 2, disabled
    wr(8'h4C, 16'h0030); // flag 3, enabled
    rd(8'h08, 16'h0006);
    wr(8'h4C, 16'h0030);
    wr(8'h08, 16'h0000); // write access clears too
    rd(8'h08, 16'h0000);
    rd(8'h48, 16'h0020);
    wr(8'h00, 16'h0008);
    cmp_bit(IRQ0_O, 1'h0);
    wr(8'h00, 16'h0009);
    cmp_bit(IRQ0_O, 1'h1);
    @(posedge CLK_I);
    IRQ0_ACK_I <= 1'h1;
    @(posedge CLK_I);
    IRQ0_ACK_I <= 1'h0;
    #1;
    cmp_bit(IRQ0_O, 1'h0);
    wr(8'h00, 16'h000D); // clear, keep enables
    rd(8'h48, 16'h0000);
    tick(16'h0005);
    rd(8'h08, 16'h0002);
    $display("test irq done");
    wr(8'h00, 16'h0002); // float function selected
    for (int i = 0; i < 3; i++)
    begin
      if (i == 2)
        wr(8'h00, 16'h0000);
      @(posedge CLK_I);
      HIZ_PIN_I <= (i != 1);
      repeat (3) @(posedge CLK_I);
      #1;
      cmp_word({9'h000, OUT_OE_N_O}, i == 0 ? 16'h007F : 16'h0000);
    end
    $display("test float done");
    end_of_test();
  end
endmodule
